// ===== hdl/wdog_pkg.sv
// Notes on behaviour
// R1 - Boot period: off, 30s, 1,2,5,10,30 min.
// R2 - Boot watchdog counts during self-test, then resets.
// R3 - Interaction pause halts boot count during popup.
// R4 - Password pause halts boot count during password.
// R5 - Runtime modes: off, one-shot, single pass, repeat.
// R6 - One-shot mode switches off on first refresh.
// R7 - Single pass runs each stage once, then stops.
// R8 - Repeat mode reruns final stage until reset.
// R9 - Start delay holds off runtime activation.
// R10 - First stage expiry raises its configured event, or a notification if none is set.
// R11 - Stages two and three have own event choice.
// R12 - First stage period from 1s to 30min.
// R13 - Later stage periods use the same set.
// R14 - Notification selects shutdown or restart.
// R15 - Shutdown notification signals over-temperature.
// R16 - Restart notification reports fatal platform error.
// R17 - Runtime watchdog starts just before OS boot.
// R18 - Refresh restarts sequence at first stage.
// R19 - Stages advance in order; disabled stage ends.
package wdog_pkg;
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_W       = 21;
  // Period codes: 0 none/off for boot and delay, 0 is 1s for stages; times in milliseconds.
  localparam logic [20:0] T_1S   = 21'd1000;
  localparam logic [20:0] T_2S   = 21'd2000;
  localparam logic [20:0] T_5S   = 21'd5000;
  localparam logic [20:0] T_10S  = 21'd10000;
  localparam logic [20:0] T_30S  = 21'd30000;
  localparam logic [20:0] T_1M   = 21'd60000;
  localparam logic [20:0] T_2M   = 21'd120000;
  localparam logic [20:0] T_5M   = 21'd300000;
  localparam logic [20:0] T_10M  = 21'd600000;
  localparam logic [20:0] T_30M  = 21'd1800000;
  localparam logic [2:0]  BOOT_SEL_RST  = 3'h0;
  localparam logic [2:0]  DELAY_SEL_RST = 3'h0;
  localparam logic [3:0]  STAGE_SEL_RST = 4'h0;
  typedef enum logic [1:0] {MODE_OFF, MODE_ONESHOT, MODE_SINGLE, MODE_REPEAT} mode_e;
  typedef enum logic [1:0] {EV_NONE, EV_NOTIFY, EV_RESET, EV_PWRBTN} event_e;
  typedef enum {RS_IDLE, RS_DELAY, RS_STAGE, RS_DONE} run_state_e;
endpackage : wdog_pkg

// ===== hdl/multistage_system_watchdog.sv
`timescale 1ns/10ps
module multistage_system_watchdog
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] boot_period_sel,
  input  wire logic       pause_interact_en,
  input  wire logic       pause_password_en,
  input  wire logic       post_running,
  input  wire logic       popup_shown,
  input  wire logic       password_wait,
  input  wire logic [1:0] run_mode,
  input  wire logic [2:0] start_delay_sel,
  input  wire logic [1:0] stage1_event,
  input  wire logic [1:0] stage2_event,
  input  wire logic [1:0] stage3_event,
  input  wire logic [3:0] stage1_period_sel,
  input  wire logic [3:0] stage2_period_sel,
  input  wire logic [3:0] stage3_period_sel,
  input  wire logic       notify_restart,
  input  wire logic       os_start,
  input  wire logic       refresh,
  output logic            sys_reset,
  output logic            pwr_button,
  output logic            over_temp,
  output logic            fatal_error,
  output logic            run_active,
  output logic [1:0]      run_stage
);

  logic [1:0] rst_sync_q;
  logic       rst_ok_n;
  logic [1:0] post_q, popup_q, pwd_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      post_q  <= 2'b00;
      popup_q <= 2'b00;
      pwd_q   <= 2'b00;
    end else begin
      post_q  <= {post_q[0], post_running};
      popup_q <= {popup_q[0], popup_shown};
      pwd_q   <= {pwd_q[0], password_wait};
    end
  end

  // Millisecond tick divider.
  logic [27:0] div_q, div_d;
  logic        tick;
  always_comb begin
    tick  = (div_q == 28'(TICK_CYCLES - 1));
    div_d = tick ? 28'h0 : div_q + 28'h1;
  end
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      div_q <= 28'h0;
    end else begin
      div_q <= div_d;
    end
  end

  function automatic logic [20:0] boot_ms(input logic [2:0] s);
    case (s) // [R1]
      3'h1:    boot_ms = T_30S;
      3'h2:    boot_ms = T_1M;
      3'h3:    boot_ms = T_2M;
      3'h4:    boot_ms = T_5M;
      3'h5:    boot_ms = T_10M;
      3'h6:    boot_ms = T_30M;
      default: boot_ms = 21'h0;
    endcase
  endfunction : boot_ms

  function automatic logic [20:0] delay_ms(input logic [2:0] s);
    case (s) // [R9]
      3'h1:    delay_ms = T_10S;
      3'h2:    delay_ms = T_30S;
      3'h3:    delay_ms = T_1M;
      3'h4:    delay_ms = T_2M;
      3'h5:    delay_ms = T_5M;
      3'h6:    delay_ms = T_10M;
      3'h7:    delay_ms = T_30M;
      default: delay_ms = 21'h0;
    endcase
  endfunction : delay_ms

  function automatic logic [20:0] stage_ms(input logic [3:0] s);
    case (s) // [R12] [R13]
      4'h0:    stage_ms = T_1S;
      4'h1:    stage_ms = T_2S;
      4'h2:    stage_ms = T_5S;
      4'h3:    stage_ms = T_10S;
      4'h4:    stage_ms = T_30S;
      4'h5:    stage_ms = T_1M;
      4'h6:    stage_ms = T_2M;
      4'h7:    stage_ms = T_5M;
      4'h8:    stage_ms = T_10M;
      default: stage_ms = T_30M;
    endcase
  endfunction : stage_ms

  // Boot-time watchdog.
  logic [20:0] boot_cnt_q, boot_cnt_d;
  logic        boot_fire_q, boot_fire_d;
  logic        boot_hold;
  always_comb begin
    boot_hold   = (pause_interact_en && (popup_q[1] || pwd_q[1])) || // [R3]
                  (pause_password_en && pwd_q[1]); // [R4]
    boot_cnt_d  = boot_cnt_q;
    boot_fire_d = 1'b0;
    if (!post_q[1] || boot_ms(boot_period_sel) == 21'h0) begin
      boot_cnt_d = 21'h0; // [R2]
    end else if (tick && !boot_hold) begin
      if (boot_cnt_q + 21'h1 >= boot_ms(boot_period_sel)) begin
        boot_fire_d = 1'b1; // [R2]
        boot_cnt_d  = 21'h0;
      end else begin
        boot_cnt_d = boot_cnt_q + 21'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      boot_cnt_q  <= 21'h0;
      boot_fire_q <= 1'b0;
    end else begin
      boot_cnt_q  <= boot_cnt_d;
      boot_fire_q <= boot_fire_d;
    end
  end

  // Runtime watchdog.
  run_state_e  st_q, st_d;
  mode_e       mode_q, mode_d;
  logic [1:0]  stg_q, stg_d;
  logic [20:0] cnt_q, cnt_d;
  logic [1:0]  ev_q, ev_d;
  logic [1:0]  cur_ev, nxt_ev;
  logic [3:0]  cur_sel;

  always_comb begin
    case (stg_q)
      2'd1: begin
        cur_ev  = stage2_event;
        cur_sel = stage2_period_sel;
      end
      2'd2: begin
        cur_ev  = stage3_event;
        cur_sel = stage3_period_sel;
      end
      default: begin
        cur_ev  = stage1_event;
        cur_sel = stage1_period_sel;
      end
    endcase
    case (stg_q)
      2'd0:    nxt_ev = stage2_event;
      2'd1:    nxt_ev = stage3_event;
      default: nxt_ev = EV_NONE;
    endcase
  end

  always_comb begin
    st_d   = st_q;
    mode_d = mode_q;
    stg_d  = stg_q;
    cnt_d  = cnt_q;
    ev_d   = EV_NONE;
    case (st_q)
      RS_IDLE: begin
        if (os_start && !post_q[1] && run_mode != MODE_OFF) begin // [R17] [R5]
          mode_d = mode_e'(run_mode);
          stg_d  = 2'd0;
          cnt_d  = 21'h0;
          st_d   = (delay_ms(start_delay_sel) == 21'h0) ? RS_STAGE : RS_DELAY;
        end
      end
      RS_DELAY: begin
        if (tick) begin
          if (cnt_q + 21'h1 >= delay_ms(start_delay_sel)) begin // [R9]
            cnt_d = 21'h0;
            st_d  = RS_STAGE;
          end else begin
            cnt_d = cnt_q + 21'h1;
          end
        end
      end
      RS_STAGE: begin
        if (refresh) begin
          stg_d = 2'd0; // [R18]
          cnt_d = 21'h0;
          if (mode_q == MODE_ONESHOT) begin
            st_d = RS_DONE; // [R6]
          end
        end else if (tick) begin
          if (cnt_q + 21'h1 >= stage_ms(cur_sel)) begin
            ev_d  = (stg_q == 2'd0 && cur_ev == EV_NONE) ? EV_NOTIFY : cur_ev; // [R10] [R11]
            cnt_d = 21'h0;
            if (stg_q != 2'd2 && nxt_ev != EV_NONE) begin
              stg_d = stg_q + 2'd1; // [R19]
            end else if (mode_q == MODE_REPEAT) begin
              stg_d = stg_q; // [R8]
            end else begin
              st_d = RS_DONE; // [R7] [R19]
            end
          end else begin
            cnt_d = cnt_q + 21'h1;
          end
        end
      end
      RS_DONE: st_d = RS_DONE;
      default: st_d = RS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      st_q   <= RS_IDLE;
      mode_q <= MODE_OFF;
      stg_q  <= 2'd0;
      cnt_q  <= 21'h0;
      ev_q   <= EV_NONE;
    end else begin
      st_q   <= st_d;
      mode_q <= mode_d;
      stg_q  <= stg_d;
      cnt_q  <= cnt_d;
      ev_q   <= ev_d;
    end
  end

  // Event outputs, one clock pulse each.
  logic rst_o_q, pwr_o_q, ot_o_q, fe_o_q;
  logic rst_o_d, pwr_o_d, ot_o_d, fe_o_d;
  always_comb begin
    rst_o_d = boot_fire_q || ev_q == EV_RESET;
    pwr_o_d = ev_q == EV_PWRBTN;
    ot_o_d  = ev_q == EV_NOTIFY && !notify_restart; // [R14] [R15]
    fe_o_d  = ev_q == EV_NOTIFY && notify_restart; // [R16]
  end
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rst_o_q <= 1'b0;
      pwr_o_q <= 1'b0;
      ot_o_q  <= 1'b0;
      fe_o_q  <= 1'b0;
    end else begin
      rst_o_q <= rst_o_d;
      pwr_o_q <= pwr_o_d;
      ot_o_q  <= ot_o_d;
      fe_o_q  <= fe_o_d;
    end
  end
  assign sys_reset   = rst_o_q;
  assign pwr_button  = pwr_o_q;
  assign over_temp   = ot_o_q;
  assign fatal_error = fe_o_q;
  assign run_active  = (st_q == RS_STAGE);
  assign run_stage   = stg_q;

  sequence s_boot_fire;
    boot_fire_q;
  endsequence
  a_boot_reset_out: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R2]
    s_boot_fire |=> sys_reset) else $error("boot expiry gave no reset");
  a_boot_post_only: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R2]
    !post_q[1] |=> boot_cnt_q == 21'h0) else $error("boot counter ran outside self-test");
  a_boot_hold_cnt: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R3]
    post_q[1] && boot_hold && boot_ms(boot_period_sel) != 21'h0 |=> $stable(boot_cnt_q))
    else $error("boot counter moved while held");
  a_oneshot_off: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R6]
    st_q == RS_STAGE && mode_q == MODE_ONESHOT && refresh |=> st_q == RS_DONE)
    else $error("one-shot did not switch off");
  a_refresh_rst: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R18]
    st_q == RS_STAGE && refresh |=> stg_q == 2'd0 && cnt_q == 21'h0)
    else $error("refresh did not restart stage one");
  a_repeat_stay: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R8]
    st_q == RS_STAGE && mode_q == MODE_REPEAT |=> st_q == RS_STAGE)
    else $error("repeat mode left stages");
  a_notify_kind: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R15]
    ev_q == EV_NOTIFY |=> (over_temp ^ fatal_error) && over_temp == !$past(notify_restart))
    else $error("notification mapped wrongly");
  a_stage_event: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R10]
    ev_q == EV_PWRBTN |=> pwr_button ##1 !pwr_button) else $error("power event not a pulse");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R17]
    st_q == RS_IDLE && post_q[1] |=> st_q == RS_IDLE) else $error("runtime began during self-test");
  sequence s_stage_expiry;
    st_q == RS_STAGE && !refresh && tick && cnt_q + 21'h1 >= stage_ms(cur_sel);
  endsequence
  a_stage_advance: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R19]
    s_stage_expiry ##0 (stg_q == 2'd0 && stage2_event != EV_NONE) |=> stg_q == 2'd1)
    else $error("stage one expiry did not advance");
  a_single_stop: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R7]
    s_stage_expiry ##0 (stg_q == 2'd2 && mode_q == MODE_SINGLE) |=> st_q == RS_DONE)
    else $error("single pass did not stop after stage three");
  a_delay_count: assert property (@(posedge clk) disable iff (!rst_ok_n) // [R9]
    st_q == RS_DELAY && tick && cnt_q + 21'h1 < delay_ms(start_delay_sel)
    |=> st_q == RS_DELAY && cnt_q == $past(cnt_q) + 21'h1)
    else $error("start delay did not count on");
endmodule : multistage_system_watchdog

// ===== tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,
  input  wire logic [3:0] ev,
  output logic            refresh
);
  int unsigned ev_cnt [4] = '{default: 0};
  initial begin
    refresh = 1'b0;
  end
  // Every event pulse is tallied so that stray events can be caught later.
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (ev[i] === 1'b1) begin
        ev_cnt[i]++;
      end
    end
  end
  // A refresh strobe is one clock wide and launched on the falling edge.
  task automatic do_refresh();
    @(negedge clk);
    refresh = 1'b1;
    @(negedge clk);
    refresh = 1'b0;
  endtask : do_refresh
endmodule : host_model

// ===== tb/multistage_system_watchdog_tb.sv
`timescale 1ns/10ps
module multistage_system_watchdog_tb;
  import wdog_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] boot_sel = 3'h0;
  logic       p_int = 1'b0;
  logic       p_pwd = 1'b0;
  logic       post = 1'b0;
  logic       popup = 1'b0;
  logic       pwd = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] dly = 3'h0;
  logic [1:0] ev1 = 2'h1;
  logic [1:0] ev2 = 2'h0;
  logic [1:0] ev3 = 2'h0;
  logic [3:0] per1 = 4'h0;
  logic [3:0] per2 = 4'h0;
  logic [3:0] per3 = 4'h0;
  logic       restart = 1'b0;
  logic       os_start = 1'b0;
  logic       refresh;
  logic [3:0] evs;
  logic       run_active;
  logic [1:0] run_stage;
  int         err_total = 0;
  int         n_tests = 0;
  int         snap;
  multistage_system_watchdog #(.TICK_CYCLES(1)) multistage_system_watchdog_i (
    .clk(clk), .rst_n(rst_n), .boot_period_sel(boot_sel), .pause_interact_en(p_int),
    .pause_password_en(p_pwd), .post_running(post), .popup_shown(popup),
    .password_wait(pwd), .run_mode(mode), .start_delay_sel(dly), .stage1_event(ev1),
    .stage2_event(ev2), .stage3_event(ev3), .stage1_period_sel(per1),
    .stage2_period_sel(per2), .stage3_period_sel(per3), .notify_restart(restart),
    .os_start(os_start), .refresh(refresh), .sys_reset(evs[2]), .pwr_button(evs[3]),
    .over_temp(evs[0]), .fatal_error(evs[1]), .run_active(run_active),
    .run_stage(run_stage));
  host_model host_model_i (.clk(clk), .ev(evs), .refresh(refresh));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  // Waits for pulse k and checks that it came about exp cycles from the call.
  task automatic wait_ev(input int k, input int exp);
    int n;
    n = 0;
    while (evs[k] !== 1'b1 && n < exp + 50) begin
      cycles(1);
      n++;
    end
    check(n + 10 >= exp && n <= exp + 10, 1'b1);
  endtask : wait_ev
  task automatic do_reset();
    rst_n = 1'b0;
    cycles(6);
    rst_n = 1'b1;
    cycles(4);
  endtask : do_reset
  task automatic start(input logic [1:0] m, input logic [2:0] d);
    mode = m;
    dly = d;
    os_start = 1'b1;
    cycles(1);
    os_start = 1'b0;
  endtask : start
  initial begin
    do_reset();
    boot_sel = 3'h1;
    p_int = 1'b1;
    post = 1'b1;
    popup = 1'b1;
    cycles(5000);
    p_int = 1'b0;
    p_pwd = 1'b1;
    pwd = 1'b1;
    cycles(5000);
    pwd = 1'b0;
    wait_ev(2, 30000);
    post = 1'b0;
    boot_sel = 3'h0;
    do_reset();
    ev2 = 2'h2;
    per2 = 4'h1;
    ev3 = 2'h3;
    per3 = 4'h2;
    start(2'h2, 3'h0);
    wait_ev(0, 1000);
    cycles(2);
    check(run_stage, 2'h1);
    wait_ev(2, 2000);
    wait_ev(3, 5000);
    cycles(3);
    check(run_active, 1'b0);
    snap = host_model_i.ev_cnt[0];
    cycles(1500);
    check(host_model_i.ev_cnt[0], snap);
    do_reset();
    ev2 = 2'h0;
    restart = 1'b1;
    per1 = 4'h1;
    start(2'h3, 3'h0);
    cycles(500);
    host_model_i.do_refresh();
    wait_ev(1, 2000);
    cycles(2);
    wait_ev(1, 2000);
    cycles(2);
    check(run_active, 1'b1);
    per1 = 4'h0;
    do_reset();
    start(2'h0, 3'h0);
    cycles(5);
    check(run_active, 1'b0);
    start(2'h1, 3'h0);
    cycles(100);
    check(run_active, 1'b1);
    host_model_i.do_refresh();
    cycles(3);
    check(run_active, 1'b0);
    snap = host_model_i.ev_cnt[1];
    cycles(1500);
    check(host_model_i.ev_cnt[1], snap);
    do_reset();
    start(2'h2, 3'h1);
    cycles(9000);
    check(run_active, 1'b0);
    host_model_i.do_refresh();
    wait_ev(1, 2000);
    finish_test();
  end
  initial begin
    #350000;
    err_total++;
    finish_test();
  end
endmodule : multistage_system_watchdog_tb
